// *** src/api_parser_pkg.sv ***
// shared constants and types for the host api frame command parser
package api_parser_pkg;
  // framing bytes and frame types
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] FT_LOCAL = 8'h08;
  localparam logic [7:0] FT_QUEUE = 8'h09;
  localparam logic [7:0] FT_TX = 8'h10;
  localparam logic [7:0] FT_CFG_RSP = 8'h88;
  localparam logic [7:0] FT_TX_STAT = 8'h8b;
  localparam logic [7:0] CHK_GOOD = 8'hff;
  // byte offsets inside a frame
  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_ID = 16'h0004;
  localparam logic [15:0] OFS_CMD_HI = 16'h0005;
  localparam logic [15:0] OFS_CMD_LO = 16'h0006;
  localparam logic [15:0] OFS_VAL = 16'h0007;
  localparam logic [15:0] OFS_DEST = 16'h0005;
  localparam logic [15:0] OFS_DEST_END = 16'h000c;
  localparam logic [15:0] OFS_RADIUS = 16'h000f;
  localparam logic [15:0] OFS_PAY = 16'h0011;
  localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_ffff;
  // two-character command identifiers
  localparam logic [15:0] CMD_APPLY = 16'h4143;
  localparam logic [15:0] CMD_RATE = 16'h4244;
  localparam logic [15:0] CMD_HOPS = 16'h4e48;
  localparam logic [15:0] CMD_SRC_EP = 16'h5345;
  localparam logic [15:0] CMD_DST_EP = 16'h4445;
  localparam logic [15:0] CMD_CLUSTER = 16'h4349;
  localparam logic [15:0] CMD_LABEL = 16'h4e49;
  localparam logic [15:0] CMD_MAXPAY = 16'h4e50;
  localparam logic [15:0] CMD_TEMP = 16'h5450;
  // parameter slots; 0..5 are stored, 6 and 7 are read-only queries
  localparam int NPARAM = 6;
  localparam logic [2:0] P_RATE = 3'h0;
  localparam logic [2:0] P_HOPS = 3'h1;
  localparam logic [2:0] P_SRC = 3'h2;
  localparam logic [2:0] P_DST = 3'h3;
  localparam logic [2:0] P_CLUSTER = 3'h4;
  localparam logic [2:0] P_LABEL = 3'h5;
  localparam logic [2:0] P_MAXPAY = 3'h6;
  localparam logic [2:0] P_TEMP = 3'h7;
  localparam logic [31:0] RST_PARAM = 32'h0000_0000;
  localparam logic [15:0] RST_MAXPAY = 16'h0100;
  // response status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ERR = 8'h01;
  localparam logic [7:0] ST_BADCMD = 8'h02;
  localparam logic [7:0] ST_TOO_BIG = 8'h74;
  localparam logic [15:0] ADDR16_UNK = 16'hfffe;
  // register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_MAXPAY = 8'h08;
  localparam logic [7:0] REG_PENDING = 8'h0c;
  // parser states
  typedef enum logic [2:0] {
    S_HUNT, S_LEN_HI, S_LEN_LO, S_BODY, S_CSUM, S_EXEC, S_RF_WAIT, S_RESP
  } st_t;
endpackage

// *** src/host_api_frame_command_parser.sv ***
// host api frame parser with input byte fifo
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

// small valid/ready fifo for the incoming byte stream
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage words
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // fill level
  } fifo_t;
  fifo_t q_r, q_nxt;
  logic push, pop;

  // full and empty straight from the level
  assign in_ready = (q_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q_r.cnt != '0);
  assign out_data = q_r.mem[q_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and level update
  always_comb
  begin
    q_nxt = q_r;
    if (push)
    begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp = (q_r.wp == AW'(DEPTH-1)) ? '0 : q_r.wp + 1'b1;
    end
    if (pop)
      q_nxt.rp = (q_r.rp == AW'(DEPTH-1)) ? '0 : q_r.rp + 1'b1;
    q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end
endmodule // byte_fifo

module host_api_frame_command_parser #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host byte stream in
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // response byte stream out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // radio transmit path
  output logic [7:0] rf_data,
  output logic rf_data_valid,
  output logic rf_end,
  output logic rf_ok,
  output logic [63:0] rf_dest,
  output logic rf_broadcast,
  output logic [7:0] rf_hops,
  output logic [7:0] rf_src_ep,
  output logic [7:0] rf_dst_ep,
  output logic [15:0] rf_cluster,
  input wire logic rf_done,
  input wire logic [7:0] rf_result,
  // configuration outputs and sensor input
  output logic [31:0] serial_rate,
  output logic [31:0] node_label,
  input wire logic [15:0] temp_value,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import api_parser_pkg::*;

  // whole block state
  typedef struct packed {
    api_parser_pkg::st_t st; // parser state
    logic [15:0] len; // body bytes still to come
    logic [15:0] pos; // offset of next body byte
    logic [7:0] sum; // running checksum
    logic [7:0] ftype; // frame type
    logic [7:0] fid; // frame id
    logic [15:0] cmd; // command identifier
    logic [31:0] val; // new value, last four bytes
    logic [2:0] nval; // value byte count, saturating
    logic [63:0] dest; // destination address
    logic [7:0] radius; // broadcast radius byte
    logic [15:0] plen; // payload byte count
    logic [NPARAM-1:0][31:0] active; // active configuration
    logic [NPARAM-1:0][31:0] pending; // queued values
    logic [NPARAM-1:0] pvalid; // queued value present
    logic [15:0] maxpay; // payload limit
    logic rkind; // response kind, 1 is config
    logic [7:0] rstatus; // response status
    logic [31:0] rval; // response value
    logic [2:0] rvlen; // response value bytes
    logic [4:0] idx; // response byte index
    logic [7:0] rsum; // response checksum
    logic [7:0] txd; // response byte out
    logic [7:0] rfd; // payload byte out
    logic rfv; // payload byte strobe
    logic rfe; // end of transmit frame strobe
    logic rfok; // transmit frame accepted
    logic [7:0] hops; // hop limit to radio
    logic [15:0] nok; // frames accepted
    logic [15:0] nbad; // frames discarded
    logic [31:0] rdat; // read data
  } state_t;
  state_t q_r, q_nxt;

  // fifo drain side
  logic [7:0] in_data;
  logic in_valid, in_ready, take;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(in_data),
    .out_valid(in_valid),
    .out_ready(in_ready)
  );

  // command to slot: bit 3 marks a known settable or query command
  function automatic logic [3:0] cmd_slot(input logic [15:0] c);
    unique case (c)
      CMD_RATE: cmd_slot = {1'b1, P_RATE};
      CMD_HOPS: cmd_slot = {1'b1, P_HOPS};
      CMD_SRC_EP: cmd_slot = {1'b1, P_SRC};
      CMD_DST_EP: cmd_slot = {1'b1, P_DST};
      CMD_CLUSTER: cmd_slot = {1'b1, P_CLUSTER};
      CMD_LABEL: cmd_slot = {1'b1, P_LABEL};
      CMD_MAXPAY: cmd_slot = {1'b1, P_MAXPAY};
      CMD_TEMP: cmd_slot = {1'b1, P_TEMP};
      default: cmd_slot = 4'h0;
    endcase
  endfunction

  // bytes returned for a query of each slot
  function automatic logic [2:0] slot_len(input logic [2:0] s);
    unique case (s)
      P_HOPS, P_SRC, P_DST: slot_len = 3'h1;
      P_CLUSTER, P_MAXPAY, P_TEMP: slot_len = 3'h2;
      default: slot_len = 3'h4;
    endcase
  endfunction

  // parser accepts bytes only while hunting or receiving a frame
  assign in_ready = (q_r.st == S_HUNT) || (q_r.st == S_LEN_HI) || (q_r.st == S_LEN_LO)
                    || (q_r.st == S_BODY) || (q_r.st == S_CSUM);
  assign take = in_valid & in_ready;

  // outputs from state
  assign tx_data = q_r.txd;
  assign tx_valid = (q_r.st == S_RESP);
  assign rf_data = q_r.rfd;
  assign rf_data_valid = q_r.rfv;
  assign rf_end = q_r.rfe;
  assign rf_ok = q_r.rfok;
  assign rf_dest = q_r.dest;
  assign rf_broadcast = (q_r.dest == BCAST_ADDR);
  assign rf_hops = q_r.hops;
  assign rf_src_ep = q_r.active[P_SRC][7:0];
  assign rf_dst_ep = q_r.active[P_DST][7:0];
  assign rf_cluster = q_r.active[P_CLUSTER][15:0];
  assign serial_rate = q_r.active[P_RATE];
  assign node_label = q_r.active[P_LABEL];
  assign reg_rdata = q_r.rdat;

  // next state of the whole block
  always_comb
  begin
    logic [3:0] slot;
    logic [15:0] rlen;
    logic [4:0] k;
    logic [7:0] nb;
    logic good;
    logic [4:0] j;
    slot = cmd_slot(q_r.cmd);
    rlen = q_r.rkind ? 16'(5 + 16'(q_r.rvlen)) : 16'h0007;
    k = q_r.idx + 5'h1;
    nb = 8'h00;
    j = 5'h0;
    good = ((q_r.sum + in_data) == CHK_GOOD);
    q_nxt = q_r;
    q_nxt.rfv = 1'b0;
    q_nxt.rfe = 1'b0;
    q_nxt.rdat = '0;
    unique case (q_r.st)
      // wait for delimiter; anything else is dropped
      S_HUNT:
      begin
        if (take && in_data == DELIM)
          q_nxt.st = S_LEN_HI;
      end
      // length high byte
      S_LEN_HI:
      begin
        if (take)
        begin
          q_nxt.len[15:8] = in_data;
          q_nxt.st = S_LEN_LO;
        end
      end
      // length low byte, clear frame fields
      S_LEN_LO:
      begin
        if (take)
        begin
          q_nxt.len[7:0] = in_data;
          q_nxt.pos = OFS_TYPE;
          q_nxt.sum = 8'h00;
          q_nxt.ftype = 8'h00;
          q_nxt.fid = 8'h00;
          q_nxt.cmd = 16'h0000;
          q_nxt.val = 32'h0;
          q_nxt.nval = 3'h0;
          q_nxt.dest = 64'h0;
          q_nxt.radius = 8'h00;
          q_nxt.plen = 16'h0000;
          q_nxt.st = ({q_r.len[15:8], in_data} == 16'h0000) ? S_HUNT : S_BODY;
        end
      end
      // body bytes, fields captured by offset
      S_BODY:
      begin
        if (take)
        begin
          q_nxt.sum = q_r.sum + in_data;
          q_nxt.pos = q_r.pos + 16'h1;
          q_nxt.len = q_r.len - 16'h1;
          if (q_r.len == 16'h1)
            q_nxt.st = S_CSUM;
          if (q_r.pos == OFS_TYPE)
            q_nxt.ftype = in_data;
          else if (q_r.pos == OFS_ID)
            q_nxt.fid = in_data;
          else if (q_r.ftype == FT_TX)
          begin
            if (q_r.pos >= OFS_DEST && q_r.pos <= OFS_DEST_END)
              q_nxt.dest = {q_r.dest[55:0], in_data};
            else if (q_r.pos == OFS_RADIUS)
              q_nxt.radius = in_data;
            else if (q_r.pos >= OFS_PAY)
            begin
              // stream the first maxpay payload bytes; radio drops them unless the end strobe says ok
              q_nxt.plen = q_r.plen + 16'h1;
              q_nxt.rfd = in_data;
              q_nxt.rfv = (q_r.plen < q_r.maxpay);
            end
          end
          else
          begin
            if (q_r.pos == OFS_CMD_HI)
              q_nxt.cmd[15:8] = in_data;
            else if (q_r.pos == OFS_CMD_LO)
              q_nxt.cmd[7:0] = in_data;
            else if (q_r.pos >= OFS_VAL)
            begin
              q_nxt.val = {q_r.val[23:0], in_data};
              if (q_r.nval != 3'h7)
                q_nxt.nval = q_r.nval + 3'h1;
            end
          end
        end
      end
      // checksum byte: accept, discard or hand to radio
      S_CSUM:
      begin
        if (take)
        begin
          q_nxt.st = S_HUNT;
          if (!good || (q_r.ftype != FT_LOCAL && q_r.ftype != FT_QUEUE
              && q_r.ftype != FT_TX))
            q_nxt.nbad = q_r.nbad + 16'h1;
          else
            q_nxt.nok = q_r.nok + 16'h1;
          if (q_r.ftype == FT_TX)
          begin
            q_nxt.rfe = 1'b1;
            q_nxt.rfok = good && (q_r.plen <= q_r.maxpay);
            if (q_r.dest != BCAST_ADDR)
              q_nxt.hops = 8'h00;
            else if (q_r.radius == 8'h00)
              q_nxt.hops = q_r.active[P_HOPS][7:0];
            else
              q_nxt.hops = q_r.radius;
            q_nxt.rkind = 1'b0;
            if (good && q_r.fid != 8'h00)
            begin
              if (q_r.plen > q_r.maxpay)
              begin
                q_nxt.rstatus = ST_TOO_BIG;
                q_nxt.idx = 5'h0;
                q_nxt.rsum = 8'h00;
                q_nxt.txd = DELIM;
                q_nxt.st = S_RESP;
              end
              else
                q_nxt.st = S_RF_WAIT;
            end
          end
          else if (good && (q_r.ftype == FT_LOCAL || q_r.ftype == FT_QUEUE))
            q_nxt.st = S_EXEC;
        end
      end
      // apply or queue a configuration command
      S_EXEC:
      begin
        q_nxt.rkind = 1'b1;
        q_nxt.rstatus = ST_OK;
        q_nxt.rvlen = 3'h0;
        q_nxt.rval = 32'h0;
        // immediate type or apply command commits every pending value
        if (q_r.ftype == FT_LOCAL || q_r.cmd == CMD_APPLY)
        begin
          for (int i = 0; i < NPARAM; i++)
            if (q_r.pvalid[i])
              q_nxt.active[i] = q_r.pending[i];
          q_nxt.pvalid = '0;
        end
        if (q_r.cmd == CMD_APPLY)
          q_nxt.rstatus = ST_OK;
        else if (!slot[3])
          q_nxt.rstatus = ST_BADCMD;
        else if (q_r.nval == 3'h0)
        begin
          // read back the active value, or maxpay and temp_value for slots 6 and 7
          q_nxt.rvlen = slot_len(slot[2:0]);
          if (slot[2:0] == P_MAXPAY)
            q_nxt.rval = {16'h0000, q_r.maxpay};
          else if (slot[2:0] == P_TEMP)
            q_nxt.rval = {16'h0000, temp_value};
          else
            q_nxt.rval = q_r.active[slot[2:0]];
        end
        else if (slot[2:0] == P_MAXPAY || slot[2:0] == P_TEMP)
          q_nxt.rstatus = ST_ERR;
        else if (q_r.ftype == FT_LOCAL)
          q_nxt.active[slot[2:0]] = q_r.val;
        else
        begin
          q_nxt.pending[slot[2:0]] = q_r.val;
          q_nxt.pvalid[slot[2:0]] = 1'b1;
        end
        q_nxt.idx = 5'h0;
        q_nxt.rsum = 8'h00;
        q_nxt.txd = DELIM;
        q_nxt.st = (q_r.fid != 8'h00) ? S_RESP : S_HUNT;
      end
      // wait for the radio outcome
      S_RF_WAIT:
      begin
        if (rf_done)
        begin
          q_nxt.rstatus = rf_result;
          q_nxt.idx = 5'h0;
          q_nxt.rsum = 8'h00;
          q_nxt.txd = DELIM;
          q_nxt.st = S_RESP;
        end
      end
      // send response bytes one per handshake
      S_RESP:
      begin
        if (tx_ready)
        begin
          if (16'(q_r.idx) == rlen + 16'h3)
            q_nxt.st = S_HUNT;
          else
          begin
            j = k - 5'h8;
            if (k == 5'h1)
              nb = rlen[15:8];
            else if (k == 5'h2)
              nb = rlen[7:0];
            else if (16'(k) == rlen + 16'h3)
              nb = CHK_GOOD - q_r.rsum;
            else if (k == 5'h3)
              nb = q_r.rkind ? FT_CFG_RSP : FT_TX_STAT;
            else if (k == 5'h4)
              nb = q_r.fid;
            else if (q_r.rkind)
            begin
              if (k == 5'h5)
                nb = q_r.cmd[15:8];
              else if (k == 5'h6)
                nb = q_r.cmd[7:0];
              else if (k == 5'h7)
                nb = q_r.rstatus;
              else
                nb = 8'(q_r.rval >> (8 * (32'(q_r.rvlen) - 1 - 32'(j))));
            end
            else
            begin
              if (k == 5'h5)
                nb = ADDR16_UNK[15:8];
              else if (k == 5'h6)
                nb = ADDR16_UNK[7:0];
              else if (k == 5'h8)
                nb = q_r.rstatus;
              else
                nb = 8'h00;
            end
            q_nxt.txd = nb;
            q_nxt.idx = k;
            if (k >= 5'h3 && 16'(k) < rlen + 16'h3)
              q_nxt.rsum = q_r.rsum + nb;
          end
        end
      end
    endcase
    // register port
    if (reg_wr && reg_addr == REG_MAXPAY)
      q_nxt.maxpay = reg_wdata[15:0];
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_STATUS: q_nxt.rdat = {q_r.nbad, q_r.nok};
        REG_RATE: q_nxt.rdat = q_r.active[P_RATE];
        REG_MAXPAY: q_nxt.rdat = {16'h0000, q_r.maxpay};
        REG_PENDING: q_nxt.rdat = {26'h0, q_r.pvalid};
        default: q_nxt.rdat = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_r <= '0;
      q_r.st <= S_HUNT;
      q_r.maxpay <= RST_MAXPAY;
      q_r.txd <= DELIM;
    end
    else
      q_r <= q_nxt;
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // checksum outcome of the byte now offered, declared before the checks use it
  logic good_chk;
  assign good_chk = ((q_r.sum + in_data) == CHK_GOOD);

  hunt_resync_a: assert property (
    q_r.st == S_HUNT && take && in_data != DELIM |=> q_r.st == S_HUNT)
    else $error("non delimiter byte left hunt");
  len_end_a: assert property (
    q_r.st == S_BODY && take && q_r.len == 16'h1 |=> q_r.st == S_CSUM)
    else $error("frame end not found from length");
  bad_sum_a: assert property (
    q_r.st == S_CSUM && take && !good_chk |=> q_r.st == S_HUNT && $stable(q_r.active))
    else $error("bad checksum frame not dropped");
  zero_id_a: assert property (
    q_r.st == S_RESP |-> q_r.fid != 8'h00)
    else $error("response sent for zero frame id");
  queue_hold_a: assert property (
    q_r.st == S_EXEC && q_r.ftype == FT_QUEUE && q_r.cmd != CMD_APPLY |=> $stable(q_r.active))
    else $error("queued value reached active set");
  apply_all_a: assert property (
    q_r.st == S_EXEC && q_r.cmd == CMD_APPLY |=> q_r.pvalid == '0)
    else $error("apply left pending values");
  rate_commit_a: assert property (
    $changed(serial_rate) |-> $past(q_r.st) == S_EXEC)
    else $error("serial rate changed outside commit");
  bcast_hops_a: assert property (
    rf_end && rf_broadcast && q_r.active[P_HOPS][7:0] != 8'h00 |-> rf_hops != 8'h00)
    else $error("broadcast hop limit lost");

  cfg_resp_c: cover property (q_r.st == S_EXEC ##1 q_r.st == S_RESP);
  tx_resp_c: cover property (q_r.st == S_RF_WAIT ##[1:20] q_r.st == S_RESP);
  discard_c: cover property (q_r.st == S_CSUM && take && !good_chk);
endmodule // host_api_frame_command_parser

`default_nettype wire

// *** bench/host_model.sv ***
// host controller model: sends api frames, collects response bytes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic mclk,
  // frames toward the parser
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // responses from the parser
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] rsp_q[$]; // collected response bytes
  logic slow = 1'b0; // stall responses every other cycle
  logic tog = 1'b0;
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // 0xff minus the byte sum of the body
  function automatic logic [7:0] csum(input logic [7:0] b[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s += b[i];
    return 8'hff - s;
  endfunction
  // delimiter, length, body, checksum; fix corrupts the checksum
  task automatic send(input logic [7:0] body[$], input logic [7:0] fix);
    logic [7:0] f[$];
    f = {8'h7e, 8'h00, 8'(body.size()), body, csum(body) ^ fix};
    foreach (f[i])
    begin
      rx_data <= f[i];
      rx_valid <= 1'b1;
      @(posedge mclk);
      while (rx_ready !== 1'b1) @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~f[f.size()-1]; // released line shows no stale byte
    @(posedge mclk); // idle edge so the next request never overlaps
  endtask
  // one stray byte outside any frame, to be dropped while hunting
  task automatic junk(input logic [7:0] b);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge mclk);
    while (rx_ready !== 1'b1) @(posedge mclk);
    rx_valid <= 1'b0;
    @(posedge mclk);
  endtask
  // response side, prompt or stalling
  always @(posedge mclk)
  begin
    tog <= ~tog;
    tx_ready <= slow ? tog : 1'b1;
    if (tx_valid === 1'b1 && tx_ready)
      rsp_q.push_back(tx_data);
  end
endmodule // host_model
`default_nettype wire

// *** bench/host_api_frame_command_parser_tb.sv ***
// self-checking bench for the host api frame command parser
`timescale 1ns/1ps
`default_nettype none
module host_api_frame_command_parser_tb;
  import api_parser_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, rx_valid, rx_ready, tx_valid, tx_ready;
  logic rf_data_valid, rf_end, rf_ok, rf_broadcast, rf_done = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] rx_data, tx_data, rf_data, rf_hops, rf_src_ep, rf_dst_ep;
  logic [7:0] rf_result = 8'h00, reg_addr = 8'h00;
  logic [15:0] rf_cluster, temp_value = 16'h1a2b;
  logic [31:0] serial_rate, node_label, reg_rdata, reg_wdata = 32'h0, d;
  logic [63:0] rf_dest;
  logic [7:0] pay_q[$]; // radio payload bytes seen
  logic [9:0] snap; // ok, broadcast, hops at frame end
  logic [2:0] rf_cnt = 3'h0;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #10 mclk = ~mclk;
  host_model HOST (.mclk, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready);
  host_api_frame_command_parser #(.FIFO_DEPTH(4)) DUT (.mclk, .rst_n, .rx_data, .rx_valid,
    .rx_ready, .tx_data, .tx_valid, .tx_ready, .rf_data, .rf_data_valid, .rf_end, .rf_ok,
    .rf_dest, .rf_broadcast, .rf_hops, .rf_src_ep, .rf_dst_ep, .rf_cluster, .rf_done,
    .rf_result, .serial_rate, .node_label, .temp_value, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  // radio side: capture payload, answer a few cycles after frame end
  always @(posedge mclk)
  begin
    if (rf_data_valid === 1'b1) pay_q.push_back(rf_data);
    if (rf_end === 1'b1) snap <= {rf_ok, rf_broadcast, rf_hops};
    rf_cnt <= (rf_end === 1'b1) ? 3'h4 : (rf_cnt != 3'h0 ? rf_cnt - 3'h1 : 3'h0);
    rf_done <= (rf_cnt == 3'h1);
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register port: one-cycle strobes, read data in the next cycle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask
  // wait for a whole response frame and compare it
  task automatic rsp_chk(input logic [7:0] body[$]);
    logic [7:0] f[$];
    f = {8'h7e, 8'h00, 8'(body.size()), body, HOST.csum(body)};
    for (int n = 0; n < 400 && HOST.rsp_q.size() < f.size(); n++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(HOST.rsp_q.size(), f.size());
    foreach (f[i]) if (i < HOST.rsp_q.size()) chk(HOST.rsp_q[i], f[i]);
    HOST.rsp_q.delete();
  endtask
  // silent frame: nothing may come back
  task automatic quiet();
    repeat (60) @(posedge mclk);
    chk(HOST.rsp_q.size(), 0);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    reg_read(REG_MAXPAY);
    chk(d, 32'h100);
    reg_read(8'h10);
    chk(d, 32'h0);
    HOST.slow = 1'b1;
    HOST.send('{FT_LOCAL, 8'h17, 8'h54, 8'h50}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h17, 8'h54, 8'h50, ST_OK, 8'h1a, 8'h2b});
    HOST.slow = 1'b0;
    HOST.send('{FT_QUEUE, 8'h53, 8'h42, 8'h44, 8'h07}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h53, 8'h42, 8'h44, ST_OK});
    chk(serial_rate, 32'h0);
    reg_read(REG_PENDING);
    chk(d, 32'h1);
    HOST.send('{FT_QUEUE, 8'h54, 8'h42, 8'h44}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h54, 8'h42, 8'h44, ST_OK, 8'h0, 8'h0, 8'h0, 8'h0});
    HOST.send('{FT_QUEUE, 8'h00, 8'h41, 8'h43}, 8'h00);
    quiet();
    chk(serial_rate, 32'h7);
    HOST.send('{FT_QUEUE, 8'h00, 8'h4e, 8'h49, 8'h45, 8'h6e, 8'h64, 8'h20}, 8'h00);
    quiet();
    chk(node_label, 32'h0);
    HOST.send('{FT_LOCAL, 8'h21, 8'h4e, 8'h48, 8'h03}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h21, 8'h4e, 8'h48, ST_OK});
    chk(node_label, 32'h456e6420);
    HOST.junk(8'h53);
    HOST.send('{FT_LOCAL, 8'h00, 8'h53, 8'h45, 8'he8}, 8'h00);
    HOST.send('{FT_LOCAL, 8'h00, 8'h43, 8'h49, 8'h00, 8'h11}, 8'h00);
    HOST.send('{FT_LOCAL, 8'h00, 8'h42, 8'h44, 8'h09}, 8'h01);
    HOST.send('{8'h33, 8'h00, 8'h42, 8'h44, 8'h09}, 8'h00);
    quiet();
    chk(serial_rate, 32'h7);
    reg_read(REG_STATUS);
    chk(d[31:16], 16'h2);
    chk(rf_src_ep, 8'he8);
    chk(rf_dst_ep, 8'h00);
    chk(rf_cluster, 16'h0011);
    reg_write(REG_MAXPAY, 32'h4);
    HOST.send('{FT_LOCAL, 8'h41, 8'h4e, 8'h50}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h41, 8'h4e, 8'h50, ST_OK, 8'h00, 8'h04});
    HOST.send('{FT_QUEUE, 8'h42, 8'h5a, 8'h5a, 8'h01}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h42, 8'h5a, 8'h5a, ST_BADCMD});
    HOST.send('{FT_LOCAL, 8'h43, 8'h54, 8'h50, 8'h01}, 8'h00);
    rsp_chk('{FT_CFG_RSP, 8'h43, 8'h54, 8'h50, ST_ERR});
    HOST.send('{FT_TX, 8'h31, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'hff, 8'hff,
      8'hff, 8'hfe, 8'h00, 8'h00, 8'hab, 8'hcd}, 8'h00);
    rsp_chk('{FT_TX_STAT, 8'h31, 8'hff, 8'hfe, 8'h00, ST_OK, 8'h00});
    chk(rf_dest, BCAST_ADDR);
    chk(snap, {2'b11, 8'h03});
    chk(pay_q.size(), 2);
    chk(pay_q[1], 8'hcd);
    pay_q.delete();
    HOST.send('{FT_TX, 8'h32, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78,
      8'hff, 8'hfe, 8'h09, 8'h00, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5}, 8'h00);
    rsp_chk('{FT_TX_STAT, 8'h32, 8'hff, 8'hfe, 8'h00, ST_TOO_BIG, 8'h00});
    chk(snap, {2'b00, 8'h00});
    chk(pay_q.size(), 4);
    test_done();
  end
endmodule // host_api_frame_command_parser_tb
`default_nettype wire
